// [shared/ifts_pkg.sv]
// package: offsets, reset values and carriers for the fast timing and status block
package ifts_pkg;
    // ------------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [31:0] FAST_HIGH_OFS   = 32'h5000141c;
    localparam logic [31:0] FAST_LOW_OFS    = 32'h50001420;
    localparam logic [31:0] INTR_STAT_OFS   = 32'h5000142c;
    localparam logic [31:0] INTR_MASK_OFS   = 32'h50001430;
    localparam logic [31:0] CLR_INTR_OFS    = 32'h50001440;
    localparam logic [31:0] CLR_ACT_OFS     = 32'h5000145c;
    localparam logic [31:0] CLR_GCALL_OFS   = 32'h50001468;
    // ------------------------------------------------------------------
    // reset values and limits
    // ------------------------------------------------------------------
    localparam logic [15:0] FAST_HIGH_RST   = 16'h0008;
    localparam logic [15:0] FAST_LOW_RST    = 16'h0017;
    localparam logic [15:0] FAST_HIGH_MIN   = 16'h0006;
    localparam logic [15:0] FAST_LOW_MIN    = 16'h0008;
    localparam logic [15:0] INTR_MASK_RST   = 16'h08ff;
    // ------------------------------------------------------------------
    // status bit positions
    // ------------------------------------------------------------------
    localparam int          GCALL_BIT       = 11;
    localparam int          START_BIT       = 10;
    localparam int          STOP_BIT        = 9;
    localparam int          ACT_BIT         = 8;
    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        gcall;
        logic        start;
        logic        stop;
        logic        activity;
    } ifts_evt_type;
endpackage : ifts_pkg

// [logic/ifts_top.sv]
// fast-speed scl period counts and upper masked status bits
`timescale 1ns/1ps
// Summary of operation
// - scl high phase at fast speed lasts fast_high_count system clocks.
// - scl low phase at fast speed lasts fast_low_count system clocks.
// - in high-speed mode the fast counts time master code, start byte, gcall.
// - writes to the fast count registers take effect only while disabled.
// - a fast high count below 6 is stored as 6.
// - a fast low count below 8 is stored as 8.
// - general_call_flag (bit 11) sets when an acked general call arrives.
// - general_call_flag holds until disable or a read of its own or the combined clear register.
// - start_seen_flag (bit 10) sets on start or repeated start, any role.
// - stop_seen_flag (bit 9) sets on stop, in slave or master role.
// - activity flag (bit 8) clears only by disable, clear reads or reset.
// - activity flag stays set after the controller goes idle.
// - masked status is raw status and-ed with the interrupt mask.
module ifts_top (
    // system
    input  wire logic        CLK_I,
    input  wire logic        SYS_RST_I,
    // register port
    input  wire logic [31:0] ADDR_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    input  wire logic [15:0] WDATA_I,
    output logic      [15:0] RDATA_O,
    // controller state
    input  wire logic        ENABLE_I,
    input  wire logic        HS_MODE_I,
    input  wire logic        HS_PREAMBLE_I,
    input  wire logic        SCL_RUN_I,
    // link domain events
    input  wire logic        LINK_CLK_I,
    input  wire logic        LINK_RST_I,
    input  wire logic        GCALL_ACK_I,
    input  wire logic        START_DET_I,
    input  wire logic        STOP_DET_I,
    input  wire logic        ACTIVE_I,
    // scl timing out
    output logic             SCL_HIGH_O,
    output logic             FAST_SEL_O
);
    // ------------------------------------------------------------------
    // link side: event toggles
    // ------------------------------------------------------------------
    // toggles carry one-cycle link pulses safely into the system clock
    ifts_pkg::ifts_evt_type tgl_ff, nxt_tgl;
    always_comb begin
        nxt_tgl          = tgl_ff;
        nxt_tgl.gcall    = tgl_ff.gcall ^ GCALL_ACK_I;
        nxt_tgl.start    = tgl_ff.start ^ START_DET_I;
        nxt_tgl.stop     = tgl_ff.stop ^ STOP_DET_I;
        nxt_tgl.activity = tgl_ff.activity ^ ACTIVE_I;
    end
    always_ff @(posedge LINK_CLK_I) begin
        if (LINK_RST_I) begin
            tgl_ff <= '0;
        end else begin
            tgl_ff <= nxt_tgl;
        end
    end

    // ------------------------------------------------------------------
    // crossing and input synchronisers
    // ------------------------------------------------------------------
    ifts_pkg::ifts_evt_type s1_ff, s2_ff, s3_ff;
    logic [2:0] ps1_ff, ps2_ff;
    ifts_pkg::ifts_evt_type evt;
    logic en, hs, pre, run;
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            s1_ff  <= '0;
            s2_ff  <= '0;
            s3_ff  <= '0;
            ps1_ff <= 3'h0;
            ps2_ff <= 3'h0;
        end else begin
            s1_ff  <= tgl_ff;
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            ps1_ff <= {HS_MODE_I, HS_PREAMBLE_I, SCL_RUN_I};
            ps2_ff <= ps1_ff;
        end
    end
    assign evt = s2_ff ^ s3_ff;
    assign en  = ENABLE_I;
    assign hs  = ps2_ff[2];
    assign pre = ps2_ff[1];
    assign run = ps2_ff[0];

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [31:0] a, input logic [31:0] o);
        return a == o;
    endfunction : hit

    logic [15:0] hcnt_ff, nxt_hcnt, lcnt_ff, nxt_lcnt;
    logic [15:0] mask_ff, nxt_mask, rdata_ff, nxt_rdata;
    logic [11:8] raw_ff, nxt_raw;
    logic [15:0] stat;
    logic        clr_all, clr_act, clr_gc;

    assign clr_all = RD_I && hit(ADDR_I, ifts_pkg::CLR_INTR_OFS);
    assign clr_act = RD_I && hit(ADDR_I, ifts_pkg::CLR_ACT_OFS);
    assign clr_gc  = RD_I && hit(ADDR_I, ifts_pkg::CLR_GCALL_OFS);
    assign stat    = {4'h0, raw_ff & mask_ff[11:8], 8'h00};

    always_comb begin
        nxt_hcnt  = hcnt_ff;
        nxt_lcnt  = lcnt_ff;
        nxt_mask  = mask_ff;
        nxt_raw   = raw_ff;
        nxt_rdata = rdata_ff;
        if (WR_I && !en) begin
            if (hit(ADDR_I, ifts_pkg::FAST_HIGH_OFS)) begin
                nxt_hcnt = (WDATA_I < ifts_pkg::FAST_HIGH_MIN) ?
                           ifts_pkg::FAST_HIGH_MIN : WDATA_I;
            end
            if (hit(ADDR_I, ifts_pkg::FAST_LOW_OFS)) begin
                nxt_lcnt = (WDATA_I < ifts_pkg::FAST_LOW_MIN) ?
                           ifts_pkg::FAST_LOW_MIN : WDATA_I;
            end
        end
        if (WR_I && hit(ADDR_I, ifts_pkg::INTR_MASK_OFS)) begin
            nxt_mask = {4'h0, WDATA_I[11:0]};
        end
        // clears first so a same-cycle event wins
        if (!en) begin
            nxt_raw = 4'h0;
        end else begin
            if (clr_gc || clr_all) begin
                nxt_raw[ifts_pkg::GCALL_BIT] = 1'b0;
            end
            if (clr_all) begin
                nxt_raw[ifts_pkg::START_BIT] = 1'b0;
                nxt_raw[ifts_pkg::STOP_BIT]  = 1'b0;
            end
            if (clr_act || clr_all) begin
                nxt_raw[ifts_pkg::ACT_BIT] = 1'b0;
            end
            if (evt.gcall) nxt_raw[ifts_pkg::GCALL_BIT] = 1'b1;
            if (evt.start) nxt_raw[ifts_pkg::START_BIT] = 1'b1;
            if (evt.stop)  nxt_raw[ifts_pkg::STOP_BIT]  = 1'b1;
            // stays set after idle
            if (evt.activity) nxt_raw[ifts_pkg::ACT_BIT] = 1'b1;
        end
        nxt_rdata = 16'h0000;
        if (RD_I) begin
            unique case (1'b1)
                hit(ADDR_I, ifts_pkg::FAST_HIGH_OFS): nxt_rdata = hcnt_ff;
                hit(ADDR_I, ifts_pkg::FAST_LOW_OFS):  nxt_rdata = lcnt_ff;
                hit(ADDR_I, ifts_pkg::INTR_STAT_OFS): nxt_rdata = stat;
                hit(ADDR_I, ifts_pkg::INTR_MASK_OFS): nxt_rdata = mask_ff;
                default:                              nxt_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            hcnt_ff  <= ifts_pkg::FAST_HIGH_RST;
            lcnt_ff  <= ifts_pkg::FAST_LOW_RST;
            mask_ff  <= ifts_pkg::INTR_MASK_RST;
            raw_ff   <= 4'h0;
            rdata_ff <= 16'h0000;
        end else begin
            hcnt_ff  <= nxt_hcnt;
            lcnt_ff  <= nxt_lcnt;
            mask_ff  <= nxt_mask;
            raw_ff   <= nxt_raw;
            rdata_ff <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------------
    // fast scl period timer
    // ------------------------------------------------------------------
    // counts are read live; keeps them stable while the bus runs
    logic [15:0] cnt_ff, nxt_cnt;
    logic        high_ff, nxt_high, fsel_ff, nxt_fsel;
    always_comb begin
        nxt_fsel = !hs || pre;
        nxt_cnt  = cnt_ff;
        nxt_high = high_ff;
        if (!run || !en) begin
            nxt_cnt  = 16'h0001;
            nxt_high = 1'b1;
        end else if (high_ff && cnt_ff >= hcnt_ff) begin
            nxt_cnt  = 16'h0001;
            nxt_high = 1'b0;
        end else if (!high_ff && cnt_ff >= lcnt_ff) begin
            nxt_cnt  = 16'h0001;
            nxt_high = 1'b1;
        end else begin
            nxt_cnt = cnt_ff + 16'h0001;
        end
    end
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            cnt_ff  <= 16'h0001;
            high_ff <= 1'b1;
            fsel_ff <= 1'b1;
        end else begin
            cnt_ff  <= nxt_cnt;
            high_ff <= nxt_high;
            fsel_ff <= nxt_fsel;
        end
    end

    assign RDATA_O    = rdata_ff;
    assign SCL_HIGH_O = high_ff;
    assign FAST_SEL_O = fsel_ff;
endmodule : ifts_top

// [sim/ifts_checker.sv]
// checker: port properties of the fast timing and status block
`timescale 1ns/1ps
module ifts_checker (
    // watched ports
    input wire logic        CLK_I,
    input wire logic        SYS_RST_I,
    input wire logic [31:0] ADDR_I,
    input wire logic        RD_I,
    input wire logic [15:0] RDATA_O,
    input wire logic        ENABLE_I,
    input wire logic        HS_MODE_I,
    input wire logic        HS_PREAMBLE_I,
    input wire logic        SCL_HIGH_O,
    input wire logic        FAST_SEL_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);
    wire rd_st = RD_I && ADDR_I == ifts_pkg::INTR_STAT_OFS;
    wire rd_hi = RD_I && ADDR_I == ifts_pkg::FAST_HIGH_OFS;
    wire rd_lo = RD_I && ADDR_I == ifts_pkg::FAST_LOW_OFS;
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    AST_STAT_RSVD: assert property (rd_st |=> RDATA_O[15:12] == 4'h0
        && RDATA_O[7:0] == 8'h00) else $error("status spare bits set");
    AST_HIGH_MIN: assert property (rd_hi |=> RDATA_O >= 16'h0006)
        else $error("fast high count below floor");
    AST_LOW_MIN: assert property (rd_lo |=> RDATA_O >= 16'h0008)
        else $error("fast low count below floor");
    AST_FAST_SEL: assert property ((!HS_MODE_I || HS_PREAMBLE_I)[*5]
        |-> FAST_SEL_O) else $error("fast counts not selected");
    AST_HS_SLOW: assert property ((HS_MODE_I && !HS_PREAMBLE_I)[*5]
        |-> !FAST_SEL_O) else $error("fast counts used in hs data");
    AST_SCL_HIGH: assert property ($rose(SCL_HIGH_O)
        |-> (SCL_HIGH_O || !ENABLE_I)[*6]) else $error("scl high short");
    AST_SCL_LOW: assert property ($fell(SCL_HIGH_O)
        |-> (!SCL_HIGH_O || !ENABLE_I)[*8]) else $error("scl low short");
    AST_DIS_CLEAR: assert property (!ENABLE_I[*3] ##0 rd_st
        |=> RDATA_O == 16'h0000) else $error("status set while off");
    cover property (rd_st ##1 RDATA_O[9]);
    cover property ($rose(SCL_HIGH_O));
    cover property (!FAST_SEL_O);
endmodule : ifts_checker
bind ifts_top ifts_checker i_chk (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
    .ADDR_I(ADDR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .ENABLE_I(ENABLE_I),
    .HS_MODE_I(HS_MODE_I), .HS_PREAMBLE_I(HS_PREAMBLE_I),
    .SCL_HIGH_O(SCL_HIGH_O), .FAST_SEL_O(FAST_SEL_O));

// [sim/ifts_bus_model.sv]
// model: remote bus parties raising condition pulses on the link clock
`timescale 1ns/1ps
module ifts_bus_model (
    // link side
    input  wire logic link_clk_i,
    // detected conditions
    output logic      gcall_o,
    output logic      start_o,
    output logic      stop_o,
    output logic      active_o
);
    initial {gcall_o, start_o, stop_o, active_o} = 4'h0;
    // one link cycle wide, launched just after an edge
    task automatic send(input ifts_pkg::ifts_evt_type e);
        @(posedge link_clk_i);
        #2;
        {gcall_o, start_o, stop_o, active_o} = e;
        @(posedge link_clk_i);
        #2;
        {gcall_o, start_o, stop_o, active_o} = 4'h0;
    endtask : send
endmodule : ifts_bus_model

// [sim/ifts_top_tb.sv]
// testbench: registers, scl timing, speed select and status flags
`timescale 1ns/1ps
module ifts_top_tb;
    logic        clk = 1'b0, rst = 1'b1, lclk = 1'b0, wr = 1'b0;
    logic        rd = 1'b0, en = 1'b0, hs = 1'b0, pre = 1'b0, run = 1'b0;
    logic [31:0] addr = 32'h0;
    logic [15:0] wdata = 16'h0, rdata, v;
    logic        scl, fsel, g, s, p, a;
    int          n_fail = 0, num_checks = 0, k;
    always #25 clk = ~clk;
    always #40 lclk = ~lclk;
    ifts_top i_dut (.CLK_I(clk), .SYS_RST_I(rst), .ADDR_I(addr), .WR_I(wr),
        .RD_I(rd), .WDATA_I(wdata), .RDATA_O(rdata), .ENABLE_I(en),
        .HS_MODE_I(hs), .HS_PREAMBLE_I(pre), .SCL_RUN_I(run),
        .LINK_CLK_I(lclk), .LINK_RST_I(rst), .GCALL_ACK_I(g),
        .START_DET_I(s), .STOP_DET_I(p), .ACTIVE_I(a),
        .SCL_HIGH_O(scl), .FAST_SEL_O(fsel));
    ifts_bus_model i_bus (.link_clk_i(lclk), .gcall_o(g), .start_o(s),
        .stop_o(p), .active_o(a));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick
    task automatic wr_reg(input logic [31:0] ad, input logic [15:0] d);
        tick(1);
        addr = ad;
        wdata = d;
        wr = 1'b1;
        tick(1);
        wr = 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [31:0] ad, output logic [15:0] d);
        tick(1);
        addr = ad;
        rd = 1'b1;
        tick(1);
        d = rdata;
        rd = 1'b0;
    endtask : rd_reg
    task automatic rc(input logic [31:0] ad, input logic [15:0] exp);
        rd_reg(ad, v);
        chk(v, exp);
    endtask : rc
    // no port handshake on the sync path, so a fixed settle wait
    task automatic ev(input logic [3:0] e, input logic [15:0] exp);
        i_bus.send(e);
        tick(10);
        rc(ifts_pkg::INTR_STAT_OFS, exp);
    endtask : ev
    task automatic span(input logic lvl, output int n);
        n = 0;
        while (scl === lvl && n < 200) begin
            tick(1);
            n++;
        end
    endtask : span
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rc(ifts_pkg::FAST_HIGH_OFS, 16'h0008);
        rc(ifts_pkg::FAST_LOW_OFS, 16'h0017);
        rc(ifts_pkg::INTR_MASK_OFS, 16'h08ff);
        rc(ifts_pkg::INTR_STAT_OFS, 16'h0000);
    endtask : t_reset
    task automatic t_write();
        en = 1'b1;
        wr_reg(ifts_pkg::FAST_HIGH_OFS, 16'h0020);
        rc(ifts_pkg::FAST_HIGH_OFS, 16'h0008);
        en = 1'b0;
        wr_reg(ifts_pkg::FAST_HIGH_OFS, 16'h0003);
        rc(ifts_pkg::FAST_HIGH_OFS, 16'h0006);
        wr_reg(ifts_pkg::FAST_LOW_OFS, 16'h0123);
        rc(ifts_pkg::FAST_LOW_OFS, 16'h0123);
        wr_reg(ifts_pkg::FAST_LOW_OFS, 16'h0007);
        rc(ifts_pkg::FAST_LOW_OFS, 16'h0008);
        wr_reg(ifts_pkg::INTR_STAT_OFS, 16'hffff);
        rc(ifts_pkg::INTR_STAT_OFS, 16'h0000);
        rc(32'h50001424, 16'h0000);
    endtask : t_write
    task automatic t_timing();
        run = 1'b1;
        en = 1'b1;
        span(1'b1, k);
        span(1'b0, k);
        chk(k[15:0], 16'h0008);
        span(1'b1, k);
        chk(k[15:0], 16'h0006);
        en = 1'b0;
        tick(1);
        run = 1'b0;
    endtask : t_timing
    task automatic t_hs();
        hs = 1'b1;
        tick(6);
        chk({15'h0, fsel}, 16'h0000);
        pre = 1'b1;
        tick(6);
        chk({15'h0, fsel}, 16'h0001);
        hs = 1'b0;
        pre = 1'b0;
    endtask : t_hs
    task automatic t_events();
        wr_reg(ifts_pkg::INTR_MASK_OFS, 16'h0f00);
        en = 1'b1;
        ev(4'h2, 16'h0200);
        ev(4'h4, 16'h0600);
        ev(4'h8, 16'h0e00);
        ev(4'h1, 16'h0f00);
        rd_reg(ifts_pkg::CLR_GCALL_OFS, v);
        rc(ifts_pkg::INTR_STAT_OFS, 16'h0700);
        rd_reg(ifts_pkg::CLR_ACT_OFS, v);
        rc(ifts_pkg::INTR_STAT_OFS, 16'h0600);
        rd_reg(ifts_pkg::CLR_INTR_OFS, v);
        rc(ifts_pkg::INTR_STAT_OFS, 16'h0000);
        wr_reg(ifts_pkg::INTR_MASK_OFS, 16'h0800);
        ev(4'hf, 16'h0800);
        en = 1'b0;
        rc(ifts_pkg::INTR_STAT_OFS, 16'h0000);
    endtask : t_events
    task automatic finish_test();
        if (n_fail == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test
    initial begin
        #300000;
        n_fail++;
        finish_test();
    end
    initial begin
        tick(10);
        rst = 1'b0;
        t_reset();
        t_write();
        t_timing();
        t_hs();
        t_events();
        finish_test();
    end
endmodule : ifts_top_tb
